// ---- hdl/scct_defines.vh ----
// scct_defines.vh: constants for the tunneled spi control channel block
`ifndef SCCT_DEFINES_VH
`define SCCT_DEFINES_VH
// register map
`define SCCT_FAST_CHANNEL_CONTROL_ADDR 8'h43
`define SCCT_FAST_CHANNEL_CONTROL_RST 8'h00
`define SCCT_RATE_CONTROL_ADDR 8'h23
`define SCCT_RATE_CONTROL_RST 8'h00
// field positions
`define SCCT_MODE_MSB 2
`define SCCT_MODE_LSB 0
`define SCCT_RATE_DIV_BIT 6
`define SCCT_FAST_RATE_BIT 4
// mode codes
`define SCCT_MODE_FWD 3'h6
`define SCCT_MODE_REV 3'h7
// back-channel frame length in oscillator cycles (20 MHz oscillator)
`define SCCT_FRAME_LEN_20M 8'h25
`define SCCT_FRAME_LEN_10M 8'h4B
`define SCCT_FRAME_LEN_5M 8'h96
// frame bit layout: bit 3 select, bit 2 sample valid, bit 1 data, bit 0 clock level
`define SCCT_FRM_SEL_BIT 3
`define SCCT_FRM_VLD_BIT 2
`define SCCT_FRM_DAT_BIT 1
`define SCCT_FRM_CLK_BIT 0
`define SCCT_FRM_W 4
`endif

// ---- hdl/scct_skid_buf.v ----
// scct_skid_buf.v: two-entry buffer with valid/ready on both sides
module scct_skid_buf (
   // clock and reset
   input wire sys_clk_i,
   input wire srst_i,
   // fill side
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [1:0] in_data_i,
   // drain side
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [1:0] out_data_o
);
   reg [1:0] mem_reg [0:1];
   reg wr_ptr_reg;
   reg rd_ptr_reg;
   reg [1:0] count_reg;
   wire push;
   wire pop;

   // honest flags from the occupancy count
   assign in_ready_o = (count_reg != 2'h2);
   assign out_valid_o = (count_reg != 2'h0);
   assign out_data_o = mem_reg[rd_ptr_reg];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // pointer and count update
   always @(posedge sys_clk_i) begin
      if (srst_i) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg <= 2'h0;
      end else begin
         if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_i;
            wr_ptr_reg <= ~wr_ptr_reg;
         end
         if (pop) rd_ptr_reg <= ~rd_ptr_reg;
         count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule // scct_skid_buf

// ---- hdl/scct_tunnel.v ----
// scct_tunnel.v: spi control channel carried on the secondary serial lane, deserializer end
//
// Overview of operation
// - channel works only while the link runs in its 2-lane configuration
// - forward mode: master at serializer; reverse mode: master at deserializer
// - control bits 2:0 select forward at 110 and reverse at 111
// - slave read data is shifted toward the master on falling spi clock
// - forward mode rebuilds clock, mosi and select from received frame bits
// - forward mode holds regenerated mosi while regenerated clock is high
// - regenerated clock lags regenerated mosi by one pixel cycle
// - reverse mode samples select and spi clock into oscillator domain
// - reverse mode captures mosi on active edge of sampled clock
// - reverse samples are buffered and sent inside back-channel frames
// - every reverse back-channel frame carries the current select level
// - at most one data-and-clock sample per back-channel frame
// - rate 5 or 10 Mbps by divider bit, 20 Mbps when fast bit set
`include "scct_defines.vh"
module scct_tunnel (
   // oscillator-domain clock and reset
   input wire sys_clk_i,
   input wire srst_i,
   // link state
   input wire two_lane_i,
   // register port
   input wire reg_wr_i,
   input wire [7:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   output reg [7:0] reg_rdata_o,
   // forward frame bits, recovered pixel clock
   input wire pix_clk_i,
   input wire fwd_sclk_bit_i,
   input wire fwd_mosi_bit_i,
   input wire fwd_sel_bit_i,
   // forward regenerated spi master outputs
   output reg tunneled_spi_clock_o,
   output reg fwd_mosi_o,
   output reg fwd_sel_n_o,
   // forward read data returned by the local slave
   input wire fwd_miso_i,
   output reg fwd_miso_bit_o,
   // reverse-mode spi pins from the local master
   input wire rev_sclk_i,
   input wire rev_mosi_i,
   input wire rev_sel_n_i,
   // reverse-mode read data toward the local master
   input wire rev_miso_bit_i,
   output reg rev_miso_o,
   // back-channel frame output
   output reg bc_frame_stb_o,
   output reg [`SCCT_FRM_W-1:0] bc_frame_o,
   // status
   output reg fwd_active_o,
   output reg rev_active_o
);
   // state localparams for the reverse framer, one-hot
   localparam ST_IDLE = 2'b01;
   localparam ST_SEND = 2'b10;

   reg [7:0] fast_channel_control_reg;
   reg [7:0] rate_control_reg;
   reg [1:0] st_reg;
   reg [7:0] frame_cnt_reg;
   reg [1:0] clk_sync_reg;
   reg [1:0] sel_sync_reg;
   reg [1:0] mosi_sync_reg;
   reg [1:0] miso_sync_reg;
   reg clk_prev_reg;
   wire fwd_en;
   wire rev_en;
   wire [7:0] frame_len;
   wire clk_rise;
   wire clk_fall;
   wire buf_in_ready;
   wire buf_out_valid;
   wire [1:0] buf_out_data;
   wire frame_tick;
   wire buf_pop;

   // decode the mode field of the fast channel control register
   function mode_is;
      input [7:0] ctl;
      input [2:0] code;
      begin
         mode_is = (ctl[`SCCT_MODE_MSB:`SCCT_MODE_LSB] == code);
      end
   endfunction

   assign fwd_en = two_lane_i && mode_is(fast_channel_control_reg, `SCCT_MODE_FWD);
   assign rev_en = two_lane_i && mode_is(fast_channel_control_reg, `SCCT_MODE_REV);

   // fast bit overrides the divider select
   assign frame_len = rate_control_reg[`SCCT_FAST_RATE_BIT] ? `SCCT_FRAME_LEN_20M :
                      (rate_control_reg[`SCCT_RATE_DIV_BIT] ? `SCCT_FRAME_LEN_10M :
                       `SCCT_FRAME_LEN_5M);

   // register write port and status readback
   always @(posedge sys_clk_i) begin
      if (srst_i) begin
         fast_channel_control_reg <= `SCCT_FAST_CHANNEL_CONTROL_RST;
         rate_control_reg <= `SCCT_RATE_CONTROL_RST;
         reg_rdata_o <= 8'h00;
         fwd_active_o <= 1'b0;
         rev_active_o <= 1'b0;
      end else begin
         if (reg_wr_i && reg_addr_i == `SCCT_FAST_CHANNEL_CONTROL_ADDR)
            fast_channel_control_reg <= reg_wdata_i;
         if (reg_wr_i && reg_addr_i == `SCCT_RATE_CONTROL_ADDR)
            rate_control_reg <= reg_wdata_i;
         if (reg_addr_i == `SCCT_FAST_CHANNEL_CONTROL_ADDR)
            reg_rdata_o <= fast_channel_control_reg;
         else if (reg_addr_i == `SCCT_RATE_CONTROL_ADDR)
            reg_rdata_o <= rate_control_reg;
         else
            reg_rdata_o <= 8'h00; // unmapped reads as zero
         fwd_active_o <= fwd_en;
         rev_active_o <= rev_en;
      end
   end

   // forward path on the pixel clock: mode level is quasi-static, so two
   // flops are enough after software reprograms the mode
   reg [1:0] fwd_en_sync_reg;
   reg [1:0] fwd_miso_sync_reg;
   reg clk_dly_reg;
   always @(posedge pix_clk_i) begin
      if (srst_i) begin
         fwd_en_sync_reg <= 2'b00;
         fwd_miso_sync_reg <= 2'b00;
         tunneled_spi_clock_o <= 1'b0;
         fwd_mosi_o <= 1'b0;
         fwd_sel_n_o <= 1'b1;
         clk_dly_reg <= 1'b0;
         fwd_miso_bit_o <= 1'b0;
      end else begin
         fwd_en_sync_reg <= {fwd_en_sync_reg[0], fwd_en};
         // slave pin settles off the pixel clock, so it is synchronised first
         fwd_miso_sync_reg <= {fwd_miso_sync_reg[0], fwd_miso_i};
         if (fwd_en_sync_reg[1]) begin
            fwd_sel_n_o <= fwd_sel_bit_i;
            // mosi only follows while the clock is low, held through the high phase
            if (!fwd_sclk_bit_i && !clk_dly_reg)
               fwd_mosi_o <= fwd_mosi_bit_i;
            clk_dly_reg <= fwd_sclk_bit_i;
            tunneled_spi_clock_o <= clk_dly_reg;
            // slave data was shifted on the falling edge; sample it back
            if (clk_dly_reg && !fwd_sclk_bit_i)
               fwd_miso_bit_o <= fwd_miso_sync_reg[1];
         end else begin
            tunneled_spi_clock_o <= 1'b0;
            fwd_sel_n_o <= 1'b1;
            clk_dly_reg <= 1'b0;
         end
      end
   end

   // reverse path synchronisers in the oscillator domain
   always @(posedge sys_clk_i) begin
      if (srst_i) begin
         clk_sync_reg <= 2'h0;
         sel_sync_reg <= 2'h3;
         mosi_sync_reg <= 2'h0;
         miso_sync_reg <= 2'h0;
         clk_prev_reg <= 1'b0;
      end else begin
         clk_sync_reg <= {clk_sync_reg[0], rev_sclk_i};
         sel_sync_reg <= {sel_sync_reg[0], rev_sel_n_i};
         mosi_sync_reg <= {mosi_sync_reg[0], rev_mosi_i};
         miso_sync_reg <= {miso_sync_reg[0], rev_miso_bit_i};
         clk_prev_reg <= clk_sync_reg[1];
      end
   end

   assign clk_rise = clk_sync_reg[1] && !clk_prev_reg;
   assign clk_fall = !clk_sync_reg[1] && clk_prev_reg;

   // returned read data is presented to the master on falling clock
   always @(posedge sys_clk_i) begin
      if (srst_i)
         rev_miso_o <= 1'b0;
      else if (rev_en && clk_fall)
         rev_miso_o <= miso_sync_reg[1];
   end

   // buffer takes {mosi, clock level} on each active clock edge while select is low, if it has room
   scct_skid_buf u_buf (
      .sys_clk_i(sys_clk_i),
      .srst_i(srst_i),
      .in_valid_i(rev_en && !sel_sync_reg[1] && clk_rise),
      .in_ready_o(buf_in_ready),
      .in_data_i({mosi_sync_reg[1], clk_sync_reg[1]}),
      .out_valid_o(buf_out_valid),
      .out_ready_i(buf_pop),
      .out_data_o(buf_out_data)
   );

   assign frame_tick = (frame_cnt_reg == 8'h00);
   assign buf_pop = (st_reg == ST_SEND) && frame_tick;

   // back-channel framer: one frame per period, one sample at most
   always @(posedge sys_clk_i) begin
      if (srst_i) begin
         st_reg <= ST_IDLE;
         frame_cnt_reg <= 8'h00;
         bc_frame_stb_o <= 1'b0;
         bc_frame_o <= {`SCCT_FRM_W{1'b0}};
      end else begin
         bc_frame_stb_o <= 1'b0;
         case (st_reg)
            ST_IDLE: begin
               if (rev_en) begin
                  st_reg <= ST_SEND;
                  frame_cnt_reg <= 8'h00;
               end
            end
            ST_SEND: begin
               if (!rev_en) begin
                  st_reg <= ST_IDLE;
               end else if (frame_tick) begin
                  frame_cnt_reg <= frame_len - 8'h01;
                  bc_frame_stb_o <= 1'b1;
                  bc_frame_o[`SCCT_FRM_SEL_BIT] <= sel_sync_reg[1];
                  bc_frame_o[`SCCT_FRM_VLD_BIT] <= buf_out_valid;
                  bc_frame_o[`SCCT_FRM_DAT_BIT] <= buf_out_valid & buf_out_data[1];
                  bc_frame_o[`SCCT_FRM_CLK_BIT] <= buf_out_valid & buf_out_data[0];
               end else begin
                  frame_cnt_reg <= frame_cnt_reg - 8'h01;
               end
            end
            default: st_reg <= ST_IDLE;
         endcase
      end
   end
endmodule // scct_tunnel

// ---- tb/scct_slave_model.sv ----
// forward-mode slave model answering on the regenerated spi clock
module scct_slave_model (
   // regenerated bus from the block
   input wire logic clk_i,
   input wire logic sel_n_i,
   // read data back to the block
   output logic miso_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] pat_reg = 8'hCC;
   initial miso_o = 1'h0;
   // shift on falling clock while selected; a released line shows the inverse, never the old bit
   always @(negedge clk_i or posedge sel_n_i) begin
      if (!sel_n_i) begin
         miso_o <= pat_reg[7];
         pat_reg <= {pat_reg[6:0], pat_reg[7]};
      end else begin
         miso_o <= ~miso_o;
      end
   end
endmodule // scct_slave_model

// ---- tb/scct_tunnel_props.sv ----
// concurrent checks on the tunnel block ports
module scct_tunnel_props (
   // clocks and reset
   input wire sys_clk_i,
   input wire srst_i,
   input wire pix_clk_i,
   // control
   input wire two_lane_i,
   input wire reg_wr_i,
   input wire [7:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   // forward path
   input wire fwd_sclk_bit_i,
   input wire fwd_mosi_bit_i,
   input wire tunneled_spi_clock_o,
   input wire fwd_mosi_o,
   // back channel and status
   input wire bc_frame_stb_o,
   input wire [3:0] bc_frame_o,
   input wire fwd_active_o,
   input wire rev_active_o
);
   logic [7:0] gap_reg;
   logic [7:0] len_reg;
   logic seen_reg;
   // cycles since last strobe; a rate write voids the interval since the frame timer finishes it at the old length
   always @(posedge sys_clk_i) begin
      if (srst_i) begin
         gap_reg <= 8'h00;
         len_reg <= 8'h96;
         seen_reg <= 1'h0;
      end else begin
         gap_reg <= bc_frame_stb_o ? 8'h01 : gap_reg + 8'h01;
         if (reg_wr_i && reg_addr_i == 8'h23) begin
            len_reg <= reg_wdata_i[4] ? 8'h25 : (reg_wdata_i[6] ? 8'h4B : 8'h96);
         end
         seen_reg <= (reg_wr_i && reg_addr_i == 8'h23) || !rev_active_o ? 1'h0 : (seen_reg | bc_frame_stb_o);
      end
   end
   sequence rev_write_s;
      reg_wr_i && reg_addr_i == 8'h43 && reg_wdata_i[2:0] == 3'h7 && two_lane_i;
   endsequence
   rev_mode_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) rev_write_s |-> ##2 rev_active_o && !fwd_active_o)
      else $error("reverse code did not select reverse mode");
   two_lane_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) !two_lane_i |=> !fwd_active_o && !rev_active_o)
      else $error("mode active without two lanes");
   first_frame_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) $rose(rev_active_o) |=> bc_frame_stb_o)
      else $error("first frame late");
   frame_len_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) bc_frame_stb_o && seen_reg |-> gap_reg == len_reg)
      else $error("frame spacing wrong");
   frame_hold_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) !bc_frame_stb_o |-> $stable(bc_frame_o))
      else $error("frame changed between strobes");
   clk_lag_a: assert property (@(posedge pix_clk_i) disable iff (srst_i)
      fwd_active_o && $past(fwd_active_o, 6) |-> tunneled_spi_clock_o == $past(fwd_sclk_bit_i, 2))
      else $error("regenerated clock timing wrong");
   mosi_hold_a: assert property (@(posedge pix_clk_i) disable iff (srst_i)
      fwd_active_o && $past(fwd_active_o, 6) && tunneled_spi_clock_o && $past(tunneled_spi_clock_o) |->
      $stable(fwd_mosi_o))
      else $error("mosi moved while clock high");
   mosi_follow_a: assert property (@(posedge pix_clk_i) disable iff (srst_i)
      fwd_active_o && $past(fwd_active_o, 6) && !$past(fwd_sclk_bit_i) && !$past(fwd_sclk_bit_i, 2) |->
      fwd_mosi_o == $past(fwd_mosi_bit_i))
      else $error("mosi not rebuilt from frame bit");
endmodule // scct_tunnel_props
bind scct_tunnel scct_tunnel_props u_scct_tunnel_props (.*);

// ---- tb/tb_scct_tunnel.sv ----
// self-checking bench for the tunneled spi control channel block
module tb_scct_tunnel;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk_i = 1'h0, pix_clk_i = 1'h0, srst_i = 1'h1, two_lane_i = 1'h1, reg_wr_i = 1'h0;
   logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
   logic fwd_sclk_bit_i = 1'h0, fwd_mosi_bit_i = 1'h0, fwd_sel_bit_i = 1'h1, fwd_miso_i;
   logic rev_sclk_i = 1'h0, rev_mosi_i = 1'h0, rev_sel_n_i = 1'h1, rev_miso_bit_i = 1'h0;
   logic tunneled_spi_clock_o, fwd_mosi_o, fwd_sel_n_o, fwd_miso_bit_o, rev_miso_o;
   logic bc_frame_stb_o, fwd_active_o, rev_active_o;
   logic [3:0] bc_frame_o;
   logic [7:0] rates [3] = '{8'h50, 8'h40, 8'h00};
   logic [7:0] lens [3] = '{8'h25, 8'h4B, 8'h96};
   logic [7:0] fexp [3] = '{8'h03, 8'h02, 8'h00};
   int fails = 0, compares = 0, n;
   scct_tunnel u_scct_tunnel (.*);
   scct_slave_model u_scct_slave_model (.clk_i(tunneled_spi_clock_o), .sel_n_i(fwd_sel_n_o), .miso_o(fwd_miso_i));
   // pixel clock offset so its edges never meet the oscillator edges
   initial begin
      forever #25 sys_clk_i = ~sys_clk_i;
   end
   initial begin
      #7;
      forever #200 pix_clk_i = ~pix_clk_i;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_of_test;
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk_i);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'h1;
      @(negedge sys_clk_i);
      reg_wr_i = 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge sys_clk_i);
      reg_addr_i = a;
      @(negedge sys_clk_i);
      chk(reg_rdata_o, exp);
   endtask
   // bounded wait; n ends as the cycle count since the call, so since the previous strobe only when called right after one
   task automatic wait_stb;
      n = 0;
      do begin
         @(negedge sys_clk_i);
         n++;
      end while (bc_frame_stb_o !== 1'h1 && n < 400);
      if (n >= 400) begin
         fails++;
         end_of_test();
      end
   endtask
   task automatic rev_edge(input logic d);
      rev_mosi_i = d;
      #200 rev_sclk_i = 1'h1;
      #200 rev_sclk_i = 1'h0;
   endtask
   initial begin
      #800 srst_i = 1'h0;
      rd(8'h43, 8'h00);
      rd(8'h23, 8'h00);
      rd(8'h55, 8'h00);
      wr(8'h43, 8'hA6);
      rd(8'h43, 8'hA6);
      chk({fwd_active_o, rev_active_o}, 8'h02);
      $display("registers done");
      // forward burst; only odd pulses are judged, where either sampling phase sees the same bit
      repeat (8) @(negedge pix_clk_i);
      fwd_sel_bit_i = 1'h0;
      // clock held high two pixel cycles; pulses spaced well beyond the round trip
      for (int i = 0; i < 4; i++) begin
         @(negedge pix_clk_i);
         fwd_mosi_bit_i = i[0];
         @(negedge pix_clk_i);
         fwd_sclk_bit_i = 1'h1;
         repeat (2) @(negedge pix_clk_i);
         fwd_sclk_bit_i = 1'h0;
         repeat (4) @(negedge pix_clk_i);
         if (i[0]) chk(fwd_miso_bit_o, (8'hCC >> (7 - i)) & 8'h01);
      end
      chk(fwd_sel_n_o, 8'h00);
      fwd_sel_bit_i = 1'h1;
      $display("forward done");
      @(negedge sys_clk_i);
      two_lane_i = 1'h0;
      wr(8'h43, 8'h07);
      chk(rev_active_o, 8'h00);
      two_lane_i = 1'h1;
      wr(8'h43, 8'h07);
      repeat (2) @(negedge sys_clk_i);
      chk({fwd_active_o, rev_active_o}, 8'h01);
      foreach (rates[k]) begin
         wr(8'h23, rates[k]);
         repeat (3) wait_stb();
         chk(n[7:0], lens[k]);
      end
      $display("rates done");
      // three samples in one slow frame: two fill the buffer, the third is refused
      rev_sel_n_i = 1'h0;
      rev_miso_bit_i = 1'h1;
      rev_edge(1'h1);
      rev_edge(1'h0);
      rev_edge(1'h1);
      for (int k = 0; k < 3; k++) begin
         wait_stb();
         chk({bc_frame_o[3:2], bc_frame_o[1] & bc_frame_o[2]}, fexp[k]);
      end
      chk(rev_miso_o, 8'h01);
      rev_sel_n_i = 1'h1;
      repeat (2) wait_stb();
      chk(bc_frame_o[3], 8'h01);
      $display("reverse done");
      end_of_test();
   end
endmodule // tb_scct_tunnel
